// ### shared/ltc_pkg.sv
// Purpose: Shared constants and types for the two-counter timebase and capture timer
// Assumes: i_clk_sys is the oscillator that feeds the prescaler
// Notes:   Register indices are word indices; the APB byte address is four times the index
package ltc_pkg;

    // Counter geometry
    localparam int          CNT_W           = 8;
    localparam int          PRESCALE        = 32;
    localparam logic [7:0]  TB1_WRAP_MAX    = 8'hF9;
    localparam logic [7:0]  CNT_ZERO        = 8'h00;
    localparam logic [7:0]  TB2_WRAP_MAX    = 8'hFF;

    // Overflow periods in oscillator periods
    localparam int          TB1_PERIOD_OSC  = 8000;
    localparam int          TB1_PERIOD_DBL  = 16000;

    // Oscillator rate
    localparam int          CLK_HZ          = 20000000;
    localparam int          CLK_PERIOD_NS   = 1000000000 / CLK_HZ;

    // APB geometry
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;

    // Register indices
    localparam logic [7:0]  IDX_CTRL2       = 8'h08;
    localparam logic [7:0]  IDX_RELOAD      = 8'h09;
    localparam logic [7:0]  IDX_CNT2        = 8'h0A;
    localparam logic [7:0]  IDX_CTRL1       = 8'h0B;
    localparam logic [7:0]  IDX_CAPTURE     = 8'h0C;

    // Second control/status field positions
    localparam int          B2_TB2_FLAG     = 0;
    localparam int          B2_TB2_EN       = 1;

    // First control/status field positions
    localparam int          B1_TB1_FLAG     = 3;
    localparam int          B1_TB1_EN       = 4;
    localparam int          B1_PERIOD_SEL   = 5;
    localparam int          B1_CAP_FLAG     = 6;
    localparam int          B1_CAP_EN       = 7;

    // Reset values
    localparam logic [7:0]  RELOAD_RST      = 8'h00;
    localparam logic [7:0]  CAPTURE_RST     = 8'h00;
    localparam logic [7:0]  CNT2_RST        = 8'h00;

    // Software-written control bits
    typedef struct packed {
        logic cap_en;
        logic period_sel;
        logic tb1_en;
        logic tb2_en;
    } ltc_ctrl_t;

    // Hardware-set event flags
    typedef struct packed {
        logic cap_flag;
        logic tb1_flag;
        logic tb2_flag;
    } ltc_flags_t;

    typedef enum logic [1:0] {
        LTC_APB_IDLE,
        LTC_APB_SETUP,
        LTC_APB_ACCESS
    } ltc_apb_phase_t;

endpackage

// ### logic/ltc_prescaler.sv
// Purpose: Divides the oscillator into a one-cycle tick every DIV cycles
// Assumes: i_run low freezes the division phase
// Notes:   The tick comes from a flip-flop and is held while frozen, so a halt never loses it
`timescale 1ns/1ps
module ltc_prescaler #(
    parameter int DIV = ltc_pkg::PRESCALE
) (
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_run,
    output logic      o_tick
);
    localparam int           CW       = $clog2(DIV);
    localparam logic [CW-1:0] LAST    = CW'(DIV - 1);
    localparam logic [CW-1:0] ONE     = CW'(1);

    logic [CW-1:0] phase;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase <= '0;
        end else if (i_run) begin
            phase <= (phase == LAST) ? '0 : phase + ONE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tick <= 1'b0;
        end else if (i_run) begin
            o_tick <= (phase == LAST);
        end
    end
endmodule

// ### logic/ltc_timer.sv
// Purpose: Timebase and capture timer with two 8-bit counters on an APB slave
// Assumes: APB with zero wait states; inputs synchronous to i_clk_sys
// Notes:   Counters advance on the divide-by-32 tick and freeze in full halt
//
// Overview of operation
// - Hidden counter one starts zero, ticks per 32
// - Counter one overflows wrapping F9h to 00h
// - Period 8000 or doubled 16000 oscillator cycles
// - Overflow sets flag one; flag and enable request
// - Reading first control register clears flag one
// - Software writes never change event flags
// - Counter two starts at reload, readable, ticks
// - Counter two past FFh reloads, overflows
// - Reload writes apply at next overflow only
// - Counter two overflow sets flag two, requests
// - Reading second control register clears flag two
// - Either capture pin edge copies counter one
// - Capture sets capture flag; flag and enable request
// - Reading capture register clears capture flag
// - Edges ignored while capture flag set
// - Capture register resets zero, read only
// - Counters stop in halt, run otherwise
// - Separate request lines, gated by global mask
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ltc_timer #(
    parameter int CNT_W = ltc_pkg::CNT_W
) (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_reset_n,
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [ltc_pkg::ADDR_W-1:0]  i_paddr,
    input  wire logic [ltc_pkg::DATA_W-1:0]  i_pwdata,
    input  wire logic [3:0]                  i_pstrb,
    output logic      [ltc_pkg::DATA_W-1:0]  o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    input  wire logic                        i_capture_input_pin,
    input  wire logic                        i_halt_mode,
    input  wire logic                        i_wait_mode,
    input  wire logic                        i_active_halt_mode,
    input  wire logic                        i_slow_mode,
    input  wire logic                        i_global_int_mask,
    output logic                             o_irq_timebase_one,
    output logic                             o_irq_timebase_two,
    output logic                             o_irq_capture,
    output logic                             o_wakeup
);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    function automatic logic [ltc_pkg::ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ltc_pkg::ADDR_W'({idx, 2'b00});
    endfunction

    function automatic logic hits(input logic [ltc_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
        hits = (a == byte_addr(idx));
    endfunction

    ltc_pkg::ltc_ctrl_t  ctrl;
    ltc_pkg::ltc_flags_t flags;
    logic [CNT_W-1:0]    cnt_one;
    logic [CNT_W-1:0]    cnt_two;
    logic [CNT_W-1:0]    reload_register;
    logic [CNT_W-1:0]    capture_register;
    logic                half_phase;
    logic                pin_prev;
    logic                presc_tick;

    // Slow mode keeps the oscillator path, so only full halt matters here
    logic running;
    assign running = !i_halt_mode;

    ltc_prescaler #(
        .DIV       (ltc_pkg::PRESCALE)
    ) u_prescaler (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_run     (running),
        .o_tick    (presc_tick)
    );

    // APB decode
    logic setup_ph;
    logic access_ph;
    logic mapped;
    logic rd_done;
    logic wr_done;
    assign setup_ph  = i_psel && !i_penable;
    assign access_ph = i_psel && i_penable;
    assign mapped    = hits(i_paddr, ltc_pkg::IDX_CTRL2)  || hits(i_paddr, ltc_pkg::IDX_RELOAD) ||
                       hits(i_paddr, ltc_pkg::IDX_CNT2)   || hits(i_paddr, ltc_pkg::IDX_CTRL1)  ||
                       hits(i_paddr, ltc_pkg::IDX_CAPTURE);
    assign rd_done   = access_ph && !i_pwrite && mapped;
    assign wr_done   = access_ph && i_pwrite && mapped && i_pstrb[0];
    assign o_pready  = 1'b1;
    assign o_pslverr = access_ph && !mapped;

    logic rd_ctrl1;
    logic rd_ctrl2;
    logic rd_capture;
    assign rd_ctrl1   = rd_done && hits(i_paddr, ltc_pkg::IDX_CTRL1);
    assign rd_ctrl2   = rd_done && hits(i_paddr, ltc_pkg::IDX_CTRL2);
    assign rd_capture = rd_done && hits(i_paddr, ltc_pkg::IDX_CAPTURE);

    // Counter one advance, halved in the doubled period setting
    logic tick_one;
    logic tick_two;
    assign tick_one = presc_tick && running && (!ctrl.period_sel || half_phase);
    assign tick_two = presc_tick && running;

    logic tb1_overflow;
    logic tb2_overflow;
    assign tb1_overflow = tick_one && (cnt_one == ltc_pkg::TB1_WRAP_MAX);
    assign tb2_overflow = tick_two && (cnt_two == ltc_pkg::TB2_WRAP_MAX);

    logic cap_edge;
    logic cap_take;
    assign cap_edge = i_capture_input_pin != pin_prev;
    assign cap_take = cap_edge && !flags.cap_flag;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            half_phase <= 1'b0;
        end else if (tick_two) begin
            half_phase <= !half_phase;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_one <= ltc_pkg::CNT_ZERO;
        end else if (tb1_overflow) begin
            cnt_one <= ltc_pkg::CNT_ZERO;
        end else if (tick_one) begin
            cnt_one <= cnt_one + ONE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_two <= ltc_pkg::CNT2_RST;
        end else if (tb2_overflow) begin
            cnt_two <= reload_register;
        end else if (tick_two) begin
            cnt_two <= cnt_two + ONE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reload_register <= ltc_pkg::RELOAD_RST;
        end else if (wr_done && hits(i_paddr, ltc_pkg::IDX_RELOAD)) begin
            reload_register <= i_pwdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl <= '0;
        end else if (wr_done) begin
            if (hits(i_paddr, ltc_pkg::IDX_CTRL1)) begin
                ctrl.cap_en     <= i_pwdata[ltc_pkg::B1_CAP_EN];
                ctrl.period_sel <= i_pwdata[ltc_pkg::B1_PERIOD_SEL];
                ctrl.tb1_en     <= i_pwdata[ltc_pkg::B1_TB1_EN];
            end
            if (hits(i_paddr, ltc_pkg::IDX_CTRL2)) begin
                ctrl.tb2_en <= i_pwdata[ltc_pkg::B2_TB2_EN];
            end
        end
    end

    // Flags move only by hardware set or clearing read; set wins
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags.tb1_flag <= 1'b0;
        end else if (tb1_overflow) begin
            flags.tb1_flag <= 1'b1;
        end else if (rd_ctrl1) begin
            flags.tb1_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags.tb2_flag <= 1'b0;
        end else if (tb2_overflow) begin
            flags.tb2_flag <= 1'b1;
        end else if (rd_ctrl2) begin
            flags.tb2_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags.cap_flag <= 1'b0;
        end else if (cap_take) begin
            flags.cap_flag <= 1'b1;
        end else if (rd_capture) begin
            flags.cap_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= i_capture_input_pin;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            capture_register <= ltc_pkg::CAPTURE_RST;
        end else if (cap_take) begin
            capture_register <= cnt_one;
        end
    end

    // Read data is loaded in the setup phase so it stands in the access phase
    logic [ltc_pkg::DATA_W-1:0] next_prdata;
    always_comb begin
        next_prdata = '0;
        if (hits(i_paddr, ltc_pkg::IDX_CTRL2)) begin
            next_prdata[ltc_pkg::B2_TB2_FLAG] = flags.tb2_flag;
            next_prdata[ltc_pkg::B2_TB2_EN]   = ctrl.tb2_en;
        end else if (hits(i_paddr, ltc_pkg::IDX_RELOAD)) begin
            next_prdata[CNT_W-1:0] = reload_register;
        end else if (hits(i_paddr, ltc_pkg::IDX_CNT2)) begin
            next_prdata[CNT_W-1:0] = cnt_two;
        end else if (hits(i_paddr, ltc_pkg::IDX_CTRL1)) begin
            next_prdata[ltc_pkg::B1_TB1_FLAG]   = flags.tb1_flag;
            next_prdata[ltc_pkg::B1_TB1_EN]     = ctrl.tb1_en;
            next_prdata[ltc_pkg::B1_PERIOD_SEL] = ctrl.period_sel;
            next_prdata[ltc_pkg::B1_CAP_FLAG]   = flags.cap_flag;
            next_prdata[ltc_pkg::B1_CAP_EN]     = ctrl.cap_en;
        end else if (hits(i_paddr, ltc_pkg::IDX_CAPTURE)) begin
            next_prdata[CNT_W-1:0] = capture_register;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prdata <= '0;
        end else if (setup_ph && !i_pwrite) begin
            o_prdata <= next_prdata;
        end
    end

    // Interrupt requests and wake-up
    logic req_one;
    logic req_two;
    logic req_cap;
    assign req_one = flags.tb1_flag && ctrl.tb1_en;
    assign req_two = flags.tb2_flag && ctrl.tb2_en;
    assign req_cap = flags.cap_flag && ctrl.cap_en;

    assign o_irq_timebase_one = req_one && !i_global_int_mask;
    assign o_irq_timebase_two = req_two && !i_global_int_mask;
    assign o_irq_capture      = req_cap && !i_global_int_mask;
    assign o_wakeup = !i_halt_mode &&
                      ((req_one && (i_wait_mode || i_active_halt_mode)) ||
                       ((req_two || req_cap) && i_wait_mode));

    // Running cycles since the last prescaler tick, for the spacing check
    logic [7:0] gap_cnt;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap_cnt <= 8'h00;
        end else if (presc_tick && running) begin
            gap_cnt <= 8'h01;
        end else if (running && !(&gap_cnt)) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    a_tb1_wrap_zero: assert property (tb1_overflow |=> cnt_one == ltc_pkg::CNT_ZERO && flags.tb1_flag)
        else $error("counter one did not wrap to zero with flag");
    a_tb1_step_one: assert property (tick_one && !tb1_overflow |=> cnt_one == $past(cnt_one) + ONE)
        else $error("counter one did not step by one");
    a_tick_spacing: assert property (presc_tick && running |=> (!(presc_tick && running)) [*8])
        else $error("prescaler tick too close");
    a_tb1_read_clear: assert property (rd_ctrl1 && !tb1_overflow |=> !flags.tb1_flag)
        else $error("timebase one flag not cleared by read");
    a_flag_write_safe: assert property (wr_done && !tb1_overflow && !tb2_overflow && !cap_take
        |=> flags == $past(flags))
        else $error("write changed an event flag");
    a_cnt2_reload: assert property (tb2_overflow |=> cnt_two == $past(reload_register) && flags.tb2_flag)
        else $error("counter two did not reload");
    a_tb2_read_clear: assert property (rd_ctrl2 && !tb2_overflow |=> !flags.tb2_flag)
        else $error("timebase two flag not cleared by read");
    a_capture_take: assert property (cap_take |=> capture_register == $past(cnt_one) && flags.cap_flag)
        else $error("capture missed counter one");
    a_capture_hold: assert property (flags.cap_flag && !rd_capture |=> $stable(capture_register))
        else $error("capture register moved while flag set");
    a_halt_freeze: assert property (i_halt_mode |=> cnt_one == $past(cnt_one) && cnt_two == $past(cnt_two))
        else $error("counter moved in halt");
    a_irq_capture: assert property (cap_take
        |=> o_irq_capture == (ctrl.cap_en && !i_global_int_mask))
        else $error("capture request wrong");
    a_wake_active_halt: assert property (i_active_halt_mode && !i_wait_mode && !i_halt_mode
        |-> o_wakeup == req_one)
        else $error("wrong wake source in active halt");
    a_cap_read_clear: assert property (rd_capture && !cap_take |=> !flags.cap_flag)
        else $error("capture flag not cleared by read");
    a_reload_no_disturb: assert property (wr_done && hits(i_paddr, ltc_pkg::IDX_RELOAD) && !tick_two
        |=> cnt_two == $past(cnt_two))
        else $error("reload write disturbed counter two");
    a_tb1_irq_level: assert property (tb1_overflow
        |=> o_irq_timebase_one == (ctrl.tb1_en && !i_global_int_mask))
        else $error("timebase one request wrong");
    a_tb2_irq_level: assert property (tb2_overflow
        |=> o_irq_timebase_two == (ctrl.tb2_en && !i_global_int_mask))
        else $error("timebase two request wrong");
    a_halt_no_wake: assert property (i_halt_mode |-> !o_wakeup)
        else $error("wake-up raised in full halt");
    a_wake_wait: assert property (i_wait_mode && !i_halt_mode && (req_two || req_cap) |-> o_wakeup)
        else $error("wait mode not woken");
    a_tb1_range: assert property (cnt_one <= ltc_pkg::TB1_WRAP_MAX)
        else $error("counter one passed its wrap point");
    a_tb1_half_rate: assert property (tick_one && ctrl.period_sel |-> half_phase)
        else $error("counter one ticked off phase");
    a_tick_period: assert property (presc_tick && running && gap_cnt != 8'h00
        |-> gap_cnt == 8'(ltc_pkg::PRESCALE))
        else $error("prescaler tick spacing wrong");
    a_slow_keeps_count: assert property (i_slow_mode && presc_tick && !i_halt_mode |-> tick_two)
        else $error("slow mode stopped counter two");
    a_tb2_step: assert property (tick_two && !tb2_overflow |=> cnt_two == $past(cnt_two) + ONE)
        else $error("counter two did not step by one");
    a_capture_ro: assert property (wr_done && hits(i_paddr, ltc_pkg::IDX_CAPTURE) && !cap_take
        |=> $stable(capture_register))
        else $error("write changed the capture register");

    c_tb1_overflow: cover property (tb1_overflow ##1 rd_ctrl1);
    c_cnt2_reload: cover property (tb2_overflow);
    c_capture: cover property (cap_take ##[1:50] rd_capture);
    c_capture_ignored: cover property (cap_edge && flags.cap_flag);
    c_double_period: cover property (tb1_overflow && ctrl.period_sel);
endmodule

// ### sim/ltc_capture_source.sv
// Purpose: External signal source that drives the capture input pin
// Assumes: Requests arrive as one-cycle pulses on i_fire
// Notes:   Each request flips the pin once, i_delay plus one cycles after it is taken
`timescale 1ns/1ps
module ltc_capture_source (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic       i_fire,
    input  wire logic [7:0] i_delay,
    output logic            o_pin
);
    logic [7:0] wait_cnt;
    logic       armed;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin    <= 1'b0;
            armed    <= 1'b0;
            wait_cnt <= 8'h00;
        end else if (i_fire) begin
            armed    <= 1'b1;
            wait_cnt <= i_delay;
        end else if (armed && wait_cnt == 8'h00) begin
            // Level then holds for many cycles, so each flip is one clean edge
            o_pin <= ~o_pin;
            armed <= 1'b0;
        end else if (armed) begin
            wait_cnt <= wait_cnt - 8'h01;
        end
    end
endmodule

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the two-counter timebase and capture timer
// Assumes: The bench waits on pready even though the slave answers at once
// Notes:   Intervals are taken from a free-running cycle count kept by the bench
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [3:0] strb;
        logic [7:0] exp_rd;
        logic       exp_err;
    } ltc_row_t;

    logic        clk     = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h00000000;
    logic [3:0]  pstrb   = 4'hF;
    logic        halt    = 1'b0;
    logic        waitm   = 1'b0;
    logic        ahalt   = 1'b0;
    logic        slow    = 1'b0;
    logic        mask    = 1'b0;
    logic        fire    = 1'b0;
    logic [7:0]  dly     = 8'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        wake;
    logic [2:0]  irq;
    int          cycle   = 0;
    int          mismatches  = 0;
    int          comparisons = 0;

    always #(ltc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    always @(posedge clk) cycle <= cycle + 1;

    ltc_timer DUT (
        .i_clk_sys(clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_capture_input_pin(pin), .i_halt_mode(halt), .i_wait_mode(waitm),
        .i_active_halt_mode(ahalt), .i_slow_mode(slow), .i_global_int_mask(mask),
        .o_irq_timebase_one(irq[0]), .o_irq_timebase_two(irq[1]),
        .o_irq_capture(irq[2]), .o_wakeup(wake)
    );

    ltc_capture_source u_src (
        .i_clk_sys(clk), .i_reset_n(reset_n), .i_fire(fire), .i_delay(dly), .o_pin(pin)
    );

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                       output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) mismatches++;
    endtask

    task automatic rd8(input logic [7:0] a, output logic [7:0] v);
        logic e;
        apb(1'b0, a, 8'h00, 4'hF, v, e);
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        logic       e;
        apb(1'b1, a, d, 4'hF, v, e);
    endtask

    task automatic wait_irq(input int which, input int limit, output int stamp);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq[which] !== 1'b1 && n < limit);
        stamp = cycle;
        if (n >= limit) mismatches++;
    endtask

    task automatic fire_at(input int t, input logic [7:0] d);
        while (cycle < t) @(posedge clk);
        fire <= 1'b1;
        dly  <= d;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(70000 * ltc_pkg::CLK_PERIOD_NS);
        mismatches++;
        $display("Watchdog expired before the tests ended");
        conclude();
    end

    initial begin
        ltc_row_t   rows [16];
        logic [7:0] v;
        logic [7:0] v2;
        logic       e;
        int         ta;
        int         tb;
        int         tc;
        rows = '{'{1'b0, 8'h28, 8'h00, 4'hF, 8'h00, 1'b0}, '{1'b0, 8'h30, 8'h00, 4'hF, 8'h00, 1'b0},
                 '{1'b0, 8'h20, 8'h00, 4'hF, 8'h00, 1'b0}, '{1'b0, 8'h24, 8'h00, 4'hF, 8'h00, 1'b0},
                 '{1'b0, 8'h2C, 8'h00, 4'hF, 8'h00, 1'b0}, '{1'b1, 8'h24, 8'hF0, 4'hF, 8'h00, 1'b0},
                 '{1'b1, 8'h24, 8'hAA, 4'hE, 8'h00, 1'b0}, '{1'b0, 8'h24, 8'h00, 4'hF, 8'hF0, 1'b0},
                 '{1'b1, 8'h20, 8'h03, 4'hF, 8'h00, 1'b0}, '{1'b0, 8'h20, 8'h00, 4'hF, 8'h02, 1'b0},
                 '{1'b1, 8'h2C, 8'hD8, 4'hF, 8'h00, 1'b0}, '{1'b0, 8'h2C, 8'h00, 4'hF, 8'h90, 1'b0},
                 '{1'b1, 8'h30, 8'h55, 4'hF, 8'h00, 1'b0}, '{1'b0, 8'h30, 8'h00, 4'hF, 8'h00, 1'b0},
                 '{1'b0, 8'h34, 8'h00, 4'hF, 8'h00, 1'b1}, '{1'b1, 8'h34, 8'h11, 4'hF, 8'h00, 1'b1}};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        // Capture register is read second, after counter two, so the capture flag starts known
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata, rows[i].strb, v, e);
            if (!rows[i].wr) `CHK("register read", rows[i].exp_rd, v)
            `CHK("slave error", rows[i].exp_err, e)
        end
        slow  <= 1'b1;
        waitm <= 1'b1;
        wait_irq(1, 9000, ta);
        rd8(8'h20, v);
        `CHK("flag two read", 8'h03, v)
        wr8(8'h24, 8'hE0);
        wait_irq(1, 600, tb);
        `CHK("period two old reload", (256 - 'hF0) * ltc_pkg::PRESCALE, tb - ta)
        rd8(8'h28, v);
        repeat (29) @(posedge clk);
        rd8(8'h28, v2);
        `CHK("counter two reloaded", 1'b1, v >= 8'hE0 && v <= 8'hE1)
        `CHK("counter two step", v + 8'h01, v2)
        rd8(8'h20, v);
        wait_irq(1, 1100, tc);
        `CHK("period two new reload", (256 - 'hE0) * ltc_pkg::PRESCALE, tc - tb)
        `CHK("wake from wait", 1'b1, wake)
        rd8(8'h2C, v);
        waitm <= 1'b0;
        ahalt <= 1'b1;
        @(posedge clk);
        `CHK("no active halt wake by two", 1'b0, wake)
        halt <= 1'b1;
        rd8(8'h28, v);
        repeat (61) @(posedge clk);
        rd8(8'h28, v2);
        `CHK("halt freeze", v, v2)
        `CHK("no wake in halt", 1'b0, wake)
        halt <= 1'b0;
        wait_irq(0, 8200, ta);
        `CHK("wake from active halt", 1'b1, wake)
        mask <= 1'b1;
        @(posedge clk);
        `CHK("masked request", 1'b0, irq[0])
        mask <= 1'b0;
        rd8(8'h2C, v);
        `CHK("flag one read", 8'h98, v)
        wait_irq(0, 8200, tb);
        `CHK("period one", ltc_pkg::TB1_PERIOD_OSC, tb - ta)
        // Edges are placed mid-step of counter one so the expected value is exact
        fire_at(tb + 176, 8'h00);
        repeat (4) @(posedge clk);
        `CHK("capture request", 1'b1, irq[2])
        rd8(8'h30, v);
        `CHK("rising capture", 8'h05, v)
        @(posedge clk);
        `CHK("capture flag cleared", 1'b0, irq[2])
        fire_at(tb + 3216, 8'h00);
        repeat (64) @(posedge clk);
        fire_at(0, 8'h14);
        repeat (40) @(posedge clk);
        rd8(8'h30, v);
        `CHK("falling capture kept", 8'h64, v)
        wr8(8'h2C, 8'hB0);
        rd8(8'h2C, v);
        wait_irq(0, 17000, ta);
        rd8(8'h2C, v);
        wait_irq(0, 17000, tb);
        `CHK("doubled period", ltc_pkg::TB1_PERIOD_DBL, tb - ta)
        // A second reset must drop the value held from the falling edge
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rd8(8'h30, v);
        `CHK("capture after reset", ltc_pkg::CAPTURE_RST, v)
        rd8(8'h2C, v);
        `CHK("first control after reset", 8'h00, v)
        rd8(8'h28, v);
        `CHK("counter two after reset", ltc_pkg::CNT2_RST, v)
        conclude();
    end
endmodule
